// file: src/pbc_defines.vh
/*
  constants for the lower half of the basic control register:
  offsets, field positions, reset values and collision test timing.
  assumes the includer uses 16-bit register data and a 25 MHz clock.
*/
`ifndef PBC_DEFINES_VH
`define PBC_DEFINES_VH

`define PBC_ADDR_W 5
`define PBC_DATA_W 16
`define PBC_ADDR_CONTROL 5'h00

`define PBC_BIT_ANEG_EN 12
`define PBC_BIT_POWER_DOWN 11
`define PBC_BIT_ISOLATE 10
`define PBC_BIT_ANEG_RESTART 9
`define PBC_BIT_DUPLEX 8
`define PBC_BIT_COL_TEST 7
`define PBC_BIT_SPEED 13
`define PBC_UPPER_LSB 12
`define PBC_UPPER_MSB 15

`define PBC_RST_POWER_DOWN 1'b0
`define PBC_RST_ISOLATE 1'b0
`define PBC_RST_ANEG_RESTART 1'b0
`define PBC_RST_DUPLEX 1'b0
`define PBC_RST_COL_TEST 1'b0
`define PBC_RST_RDATA 16'h0000
`define PBC_RESERVED_LOW 7'h00
`define PBC_NIB_W 4
`define PBC_NIB_IDLE 4'h0
`define PBC_RST_OUT 1'b0
`define PBC_RST_OE_N 1'b1

// timing in ns and bit times; counts are derived from these
`define PBC_CLK_NS 40
`define PBC_BIT_NS_FAST 10
`define PBC_COL_ON_BITS 512
`define PBC_COL_OFF_BITS 4
`define PBC_COL_ON_MAX_CYC ((`PBC_COL_ON_BITS * `PBC_BIT_NS_FAST) / `PBC_CLK_NS)
`define PBC_COL_OFF_MAX_CYC ((`PBC_COL_OFF_BITS * `PBC_BIT_NS_FAST) / `PBC_CLK_NS)

`endif

// file: src/pbc_col_test.v
/*
  collision test: drives a collision indication from the transmit enable.
  assumes tx_en is synchronous to the caller's clock, and that the caller
  registers the result once on its way to the mac pins.
*/
`timescale 1ns/1ns
`include "pbc_defines.vh"

module pbc_col_test
(
  // control
  input wire enable,
  input wire tx_en,
  // result
  output reg col
);

  // left unregistered: a second flop would take 8 bit times at 100 Mb/s
  // against a limit of 4, so the caller's output flop is the only stage
  always @*
  begin
    col = enable & tx_en; // [R07] [R08]
  end

endmodule

// file: src/pbc_control.v
/*
  lower half of the basic control register of a 10/100 transceiver,
  plus the gating that power down and isolate apply to the mac side.
  assumes a management frame decoder delivers address, data and a
  one-cycle write strobe on clk, and that the negotiation engine,
  speed logic and upper control bits live outside.
*/
// Operation
// (R01) power down shuts all transceiver functions off while the register block keeps working.
// (R02) isolate at bit 10, reset 0, cuts the port from the mac side but leaves management alive.
// (R03) writing 1 to bit 9 restarts negotiation; it reads 1 until negotiation starts, then clears.
// (R04) a write of 1 to the restart bit is ignored while negotiation enable (bit 12) is 0.
// (R05) a write of 0 to the restart bit does not disturb negotiation already under way.
// (R06) bit 8 picks forced duplex with negotiation off: 1 full, 0 half.
// (R07) with collision test (bit 7, reset 0) set, col rises within 512 bit times of tx_en.
// (R08) in collision test, col falls within 4 bit times after tx_en falls.
// (R09) bits 6 to 0 ignore writes and read as zero.
// (R10) while negotiation is enabled the forced duplex and speed bits are not applied.
// (R11) while isolated the receive outputs are inactive and undriven and tx inputs are ignored.
`timescale 1ns/1ns
`include "pbc_defines.vh"

module pbc_control
(
  // clock and reset
  input wire clk,
  input wire arst_n,
  // management register access
  input wire [`PBC_ADDR_W-1:0] reg_addr,
  input wire [`PBC_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  output reg [`PBC_DATA_W-1:0] reg_rdata_q,
  // upper control bits, held outside (15:12)
  input wire [3:0] ctrl_upper,
  // negotiation engine
  input wire aneg_started,
  output reg aneg_restart_q,
  output reg duplex_full_q,
  output reg speed_100_q,
  // core enable
  output reg core_enable_q,
  // mac-side transmit inputs
  input wire mii_tx_en,
  input wire mii_tx_er,
  input wire [3:0] mii_txd,
  // transmit toward core
  output reg core_tx_en_q,
  output reg core_tx_er_q,
  output reg [3:0] core_txd_q,
  // receive from core
  input wire core_rx_dv,
  input wire core_rx_er,
  input wire core_crs,
  input wire core_col,
  input wire [3:0] core_rxd,
  // negotiated results from engine
  input wire aneg_duplex_full,
  input wire aneg_speed_100,
  // mac-side receive outputs
  output reg mii_rx_dv_q,
  output reg mii_rx_er_q,
  output reg mii_crs_q,
  output reg mii_col_q,
  output reg [3:0] mii_rxd_q,
  output reg mii_rx_oe_n_q
);

  reg power_down_q;
  reg isolate_q;
  reg duplex_q;
  reg col_test_q;
  reg aneg_restart_d;
  wire ctrl_wr;
  wire aneg_en;
  wire forced_speed;
  wire mac_live;
  wire test_col;
  wire [`PBC_DATA_W-1:0] ctrl_view;

  // single mapped address, shared by the write and the read decode
  function is_ctrl_addr;
    input [`PBC_ADDR_W-1:0] addr;
    begin
      is_ctrl_addr = (addr == `PBC_ADDR_CONTROL);
    end
  endfunction

  // mac-side gates: power down and isolate both force idle levels
  function gate_bit;
    input live;
    input bit_in;
    begin
      gate_bit = live & bit_in;
    end
  endfunction

  function [`PBC_NIB_W-1:0] gate_nib;
    input live;
    input [`PBC_NIB_W-1:0] nib_in;
    begin
      gate_nib = live ? nib_in : `PBC_NIB_IDLE;
    end
  endfunction

  assign ctrl_wr = reg_wr && is_ctrl_addr(reg_addr);
  assign aneg_en = ctrl_upper[`PBC_BIT_ANEG_EN-`PBC_UPPER_LSB];
  assign forced_speed = ctrl_upper[`PBC_BIT_SPEED-`PBC_UPPER_LSB];
  assign mac_live = !isolate_q && !power_down_q; // [R01] [R11]

  assign ctrl_view = {ctrl_upper, power_down_q, isolate_q, aneg_restart_q, duplex_q,
                      col_test_q, `PBC_RESERVED_LOW}; // [R09]

  // restart request: a new write of 1 beats the engine's start, so none is lost
  always @*
  begin
    aneg_restart_d = aneg_restart_q;
    if (!aneg_en)
      aneg_restart_d = 1'b0;
    else if (ctrl_wr && reg_wdata[`PBC_BIT_ANEG_RESTART])
      aneg_restart_d = 1'b1; // [R03] [R04]
    else if (aneg_started)
      aneg_restart_d = 1'b0; // [R03]
    // a written 0 never lands here, so running negotiation is untouched [R05]
  end

  // control bits
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      power_down_q <= `PBC_RST_POWER_DOWN;
      isolate_q <= `PBC_RST_ISOLATE;
      duplex_q <= `PBC_RST_DUPLEX;
      col_test_q <= `PBC_RST_COL_TEST;
      aneg_restart_q <= `PBC_RST_ANEG_RESTART;
    end
    else
    begin
      aneg_restart_q <= aneg_restart_d;
      if (ctrl_wr)
      begin
        power_down_q <= reg_wdata[`PBC_BIT_POWER_DOWN]; // [R01]
        isolate_q <= reg_wdata[`PBC_BIT_ISOLATE]; // [R02]
        duplex_q <= reg_wdata[`PBC_BIT_DUPLEX]; // [R06]
        col_test_q <= reg_wdata[`PBC_BIT_COL_TEST]; // [R07]
      end
    end
  end

  // read data follows the address every cycle; unmapped reads give zero
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata_q <= `PBC_RST_RDATA;
    else if (is_ctrl_addr(reg_addr))
      reg_rdata_q <= ctrl_view;
    else
      reg_rdata_q <= `PBC_RST_RDATA;
  end

  // effective mode: forced bits only count with negotiation off
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      duplex_full_q <= `PBC_RST_OUT;
      speed_100_q <= `PBC_RST_OUT;
      core_enable_q <= `PBC_RST_OUT;
    end
    else
    begin
      duplex_full_q <= aneg_en ? aneg_duplex_full : duplex_q; // [R06] [R10]
      speed_100_q <= aneg_en ? aneg_speed_100 : forced_speed; // [R10]
      core_enable_q <= !power_down_q; // [R01]
    end
  end

  // collision test runs on the raw tx enable; gating happens at the mac pins
  pbc_col_test u_col_test
  (
    .enable(col_test_q),
    .tx_en(mii_tx_en),
    .col(test_col)
  );

  // transmit toward core; a dead mac side must not start a frame
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      core_tx_en_q <= `PBC_RST_OUT;
      core_tx_er_q <= `PBC_RST_OUT;
      core_txd_q <= `PBC_NIB_IDLE;
    end
    else
    begin
      core_tx_en_q <= gate_bit(mac_live, mii_tx_en); // [R11]
      core_tx_er_q <= gate_bit(mac_live, mii_tx_er); // [R11]
      core_txd_q <= gate_nib(mac_live, mii_txd); // [R11]
    end
  end

  // mac-side receive; outputs are zeroed on power down or isolate and released on isolate, so a
  // floating bus never shows stale frame data
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mii_rx_dv_q <= `PBC_RST_OUT;
      mii_rx_er_q <= `PBC_RST_OUT;
      mii_crs_q <= `PBC_RST_OUT;
      mii_col_q <= `PBC_RST_OUT;
      mii_rxd_q <= `PBC_NIB_IDLE;
      mii_rx_oe_n_q <= `PBC_RST_OE_N;
    end
    else
    begin
      mii_rx_dv_q <= gate_bit(mac_live, core_rx_dv & !col_test_q); // [R11]
      mii_rx_er_q <= gate_bit(mac_live, core_rx_er); // [R11]
      mii_crs_q <= gate_bit(mac_live, core_crs); // [R11]
      // one flop from tx_en keeps col inside 4 bit times of its fall
      mii_col_q <= gate_bit(mac_live, col_test_q ? test_col : core_col); // [R07] [R08]
      mii_rxd_q <= gate_nib(mac_live, core_rxd); // [R11]
      mii_rx_oe_n_q <= isolate_q; // [R02] [R11]
    end
  end

endmodule

// file: tb/pbc_control_sva.sv
/* port checker for pbc_control
   assumes one clock domain and arst_n async low */
`timescale 1ns/1ns
module pbc_control_sva
(
  // clock and reset
  input wire clk,
  input wire arst_n,
  // register access
  input wire [4:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire [15:0] reg_rdata_q,
  input wire [3:0] ctrl_upper,
  // negotiation
  input wire aneg_started,
  input wire aneg_restart_q,
  // mac side
  input wire core_enable_q,
  input wire mii_tx_en,
  input wire mii_col_q,
  input wire mii_rx_oe_n_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire w0 = reg_wr && reg_addr == 5'h00;
  iso_on_a: assert property (w0 && reg_wdata[10] ##1 !reg_wr |=> mii_rx_oe_n_q)
    else $error("isolate late");
  pdown_on_a: assert property (w0 && reg_wdata[11] ##1 !reg_wr |=> !core_enable_q)
    else $error("power down late");
  rsv_zero_a: assert property (reg_rdata_q[6:0] == 7'h00)
    else $error("reserved bits set");
  restart_ign_a: assert property (w0 && !ctrl_upper[0] && !aneg_restart_q
    |=> !aneg_restart_q)
    else $error("restart taken");
  restart_set_a: assert property (w0 && reg_wdata[9] && ctrl_upper[0] |=> aneg_restart_q)
    else $error("restart lost");
  restart_hold_a: assert property (aneg_restart_q && ctrl_upper[0] && !aneg_started
    |=> aneg_restart_q)
    else $error("restart dropped");
  restart_clr_a: assert property (aneg_started && !w0 |=> !aneg_restart_q)
    else $error("restart stuck");
  // 512 bit times at 100 Mb/s is 128 clocks
  col_on_a: assert property ($rose(mii_tx_en) && reg_addr == 5'h00
    && reg_rdata_q[11:7] == 5'h01 |-> ##[1:128] mii_col_q)
    else $error("col late");
  // 4 bit times at 100 Mb/s is one clock
  col_off_a: assert property ($fell(mii_tx_en) && reg_addr == 5'h00 && reg_rdata_q[7]
    |-> ##1 !mii_col_q)
    else $error("col stuck");
endmodule
bind pbc_control pbc_control_sva u_sva(.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rdata_q, .ctrl_upper, .aneg_started, .aneg_restart_q, .core_enable_q, .mii_tx_en,
  .mii_col_q, .mii_rx_oe_n_q);

// file: tb/pbc_aneg_model.sv
/* negotiation engine stand-in answering restart requests
   assumes restart is a level on clk */
`timescale 1ns/1ns
module pbc_aneg_model
(
  // clock and reset
  input wire clk,
  input wire arst_n,
  // request and answer
  input wire restart,
  output logic started_q
);
  logic [3:0] cnt_q;
  // slow on purpose so a pending request can be read back
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      cnt_q <= 4'h0;
      started_q <= 1'b0;
    end
    else
    begin
      started_q <= restart && cnt_q == 4'hc;
      cnt_q <= (restart && !started_q) ? cnt_q + 4'h1 : 4'h0;
    end
endmodule

// file: tb/tb_pbc_control.sv
/* bench for pbc_control: register, restart, duplex, collision, isolate
   assumes pbc_aneg_model as negotiation engine */
`timescale 1ns/1ns
module tb_pbc_control;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic wr = 1'b0;
  logic tx = 1'b0;
  logic [4:0] ad = 5'h00;
  logic [15:0] wd = 16'h0000;
  logic [15:0] m = 16'h0000;
  logic [3:0] up = 4'h1;
  logic st;
  wire [15:0] rd;
  wire rs, dup, cen, ctx, col, oen;
  wire spd, cter, rdv, rer, crs;
  wire [3:0] ctxd;
  wire [3:0] rxd;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  pbc_aneg_model u_aneg(.clk(clk), .arst_n(arst_n), .restart(rs), .started_q(st));
  pbc_control u_dut(.clk(clk), .arst_n(arst_n), .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr),
    .reg_rdata_q(rd), .ctrl_upper(up), .aneg_started(st), .aneg_restart_q(rs),
    .duplex_full_q(dup), .speed_100_q(spd), .core_enable_q(cen), .mii_tx_en(tx),
    .mii_tx_er(m[0]), .mii_txd(m[4:1]), .core_tx_en_q(ctx), .core_tx_er_q(cter),
    .core_txd_q(ctxd), .core_rx_dv(m[5]), .core_rx_er(m[6]), .core_crs(m[7]),
    .core_col(m[8]), .core_rxd(m[12:9]), .aneg_duplex_full(m[13]), .aneg_speed_100(m[14]),
    .mii_rx_dv_q(rdv), .mii_rx_er_q(rer), .mii_crs_q(crs), .mii_col_q(col), .mii_rxd_q(rxd),
    .mii_rx_oe_n_q(oen));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic test_done;
    if (err_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wreg(input logic [3:0] u, input logic [15:0] d);
    @(posedge clk);
    up <= u;
    wr <= 1'b1;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic txe(input logic v, input int n);
    @(posedge clk);
    tx <= v;
    repeat (n) @(posedge clk);
    #1;
  endtask
  // hang guard, far above the ~100 clocks the sequence needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      test_done();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    m <= 16'hffff;
    wreg(4'h0, 16'hffff);
    chk(rd, 16'h0d80);
    chk(cen, 1'b0);
    chk(oen, 1'b1);
    chk(dup, 1'b1);
    chk(spd, 1'b0);
    chk(rxd, 4'h0);
    chk({rdv, rer, crs}, 3'h0);
    wreg(4'h2, 16'h0800);
    chk(rd, 16'h2800);
    chk(oen, 1'b0);
    chk(spd, 1'b1);
    chk(col, 1'b0);
    txe(1'b1, 3);
    chk(ctx, 1'b0);
    chk({cter, ctxd}, 5'h00);
    wreg(4'h0, 16'h0000);
    chk(dup, 1'b0);
    chk(spd, 1'b0);
    chk(ctx, 1'b1);
    chk({cter, ctxd}, 5'h1f);
    chk(rxd, 4'hf);
    chk({rdv, rer, crs}, 3'h7);
    txe(1'b0, 1);
    wreg(4'h1, 16'h0200);
    chk(rd, 16'h1200);
    wreg(4'h1, 16'h0000);
    chk(rd, 16'h1200);
    chk(dup, 1'b1);
    chk(spd, 1'b1);
    repeat (20) @(posedge clk);
    #1;
    chk(rd, 16'h1000);
    wreg(4'h1, 16'h0080);
    txe(1'b1, 20);
    chk(col, 1'b1);
    txe(1'b0, 1);
    chk(col, 1'b0);
    @(posedge clk);
    ad <= 5'h01;
    repeat (2) @(posedge clk);
    #1;
    chk(rd, 16'h0000);
    @(posedge clk);
    ad <= 5'h00;
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(rd, 16'h1000);
    chk(oen, 1'b0);
    test_done();
  end
endmodule
